/* hw/float_map.vh */
// constants for the floating-point function unit set: opcodes, widths, latencies.
// assumes one clock; operands and the trigger come from logic on that clock.
// Operation
// - adder: add and subtract, 5-cycle latency
// - radix-4 divider, latency mantissa half plus 3
// - multiply-accumulate a+b*c, a-b*c, 6 cycles
// - second variant: add, subtract, multiply via accumulate
// - first accumulate variant ignores special operand values
// - digit-serial square root, latency mantissa plus 3
// - int/float conversions both ways, 4 cycles
// - converter rounds to nearest, ties even
// - compares, absolute, negate, 1-cycle latency
// - arithmetic results truncate toward zero
// - denormal inputs and results become zero
// - quotient within 4 units last place
// - operands in sign, exponent, mantissa layout
// - half-width builds may skip special values
// - mantissa, exponent, integer widths are parameters
`ifndef FLOAT_MAP_VH
`define FLOAT_MAP_VH
`define MANT_W        23
`define EXP_W         8
`define INT_W         32
`define OP_ADD        5'h00
`define OP_SUB        5'h01
`define OP_MUL        5'h02
`define OP_DIV        5'h03
`define OP_MAC        5'h04
`define OP_MSU        5'h05
`define OP_MAC2       5'h06
`define OP_MSU2       5'h07
`define OP_ADD2       5'h08
`define OP_SUB2       5'h09
`define OP_MUL2       5'h0A
`define OP_SQRT       5'h0B
`define OP_CIF        5'h0C
`define OP_CIFU       5'h0D
`define OP_CFI        5'h0E
`define OP_CFIU       5'h0F
`define OP_EQ         5'h10
`define OP_NE         5'h11
`define OP_GT         5'h12
`define OP_GE         5'h13
`define OP_LT         5'h14
`define OP_LE         5'h15
`define OP_ABS        5'h16
`define OP_NEG        5'h17
`define LAT_ADD       5
`define LAT_MUL       5
`define LAT_DIV_EXTRA 3
`define LAT_MAC       6
`define LAT_SQRT_EXTRA 3
`define LAT_CONV      4
`define LAT_CMP       1
`endif

/* hw/float_unit_set.v */
// floating-point function units: add/sub, mul, div, two accumulate variants, sqrt, convert, compare.
// assumes trigger, opcode and operands come from same-clock logic; one operation issued per cycle.
`timescale 1ns/1ps
`include "float_map.vh"

module result_pipe #(
  parameter LAT = 1,
  parameter W   = 32
) (
  input  wire         mclk,
  input  wire         rstn,
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  output wire [W-1:0] out_data
);
  reg [W:0] stage_reg [0:LAT-1];
  genvar g;
  generate
    for (g = 0; g < LAT; g = g + 1) begin : st
      always @(posedge mclk or negedge rstn) begin
        if (!rstn)
          stage_reg[g] <= {(W+1){1'b0}};
        else if (g == 0)
          stage_reg[g] <= {in_valid, in_data};
        else
          stage_reg[g] <= stage_reg[(g == 0) ? 0 : g-1];
      end
    end
  endgenerate
  assign out_valid = stage_reg[LAT-1][W];
  assign out_data  = stage_reg[LAT-1][W-1:0];
endmodule

module float_unit_set #(
  parameter mantissa_width  = `MANT_W,
  parameter exponent_width  = `EXP_W,
  parameter int_width       = `INT_W,
  parameter handle_specials = 1
) (
  input  wire                                   mclk,
  input  wire                                   rstn,
  input  wire                                   trigger,
  input  wire [4:0]                             opcode,
  input  wire [exponent_width+mantissa_width:0] operand_a,
  input  wire [exponent_width+mantissa_width:0] operand_b,
  input  wire [exponent_width+mantissa_width:0] operand_c,
  output wire [exponent_width+mantissa_width:0] add_result,
  output wire                                   add_valid,
  output wire [exponent_width+mantissa_width:0] mul_result,
  output wire                                   mul_valid,
  output wire [exponent_width+mantissa_width:0] div_result,
  output wire                                   div_valid,
  output wire [exponent_width+mantissa_width:0] mac_result,
  output wire                                   mac_valid,
  output wire [exponent_width+mantissa_width:0] mac2_result,
  output wire                                   mac2_valid,
  output wire [exponent_width+mantissa_width:0] sqrt_result,
  output wire                                   sqrt_valid,
  output wire [exponent_width+mantissa_width:0] conv_result,
  output wire                                   conv_valid,
  output wire [exponent_width+mantissa_width:0] cmp_result,
  output wire                                   cmp_valid
);
  localparam MW   = mantissa_width;
  localparam EW   = exponent_width;
  localparam IW   = int_width;
  localparam W    = EW + MW + 1;
  localparam BIAS = (1 << (EW - 1)) - 1;
  localparam EMAX = (1 << EW) - 1;
  localparam P    = 2 * MW + 2;
  localparam A    = P + 4;
  localparam DN   = (MW + 3) / 2;
  localparam LAT_DIV  = (MW + 1) / 2 + `LAT_DIV_EXTRA;
  localparam LAT_SQRT = MW + `LAT_SQRT_EXTRA;
  localparam [W-1:0] QNAN = {1'b0, {EW{1'b1}}, 1'b1, {(MW-1){1'b0}}};
  localparam [W-1:0] ONE  = {2'b00, {(EW-1){1'b1}}, {MW{1'b0}}};

  function is_zero; input [W-1:0] x; is_zero = (x[W-2:MW] == {EW{1'b0}}); endfunction
  function is_nan;  input [W-1:0] x; is_nan = (&x[W-2:MW]) && (|x[MW-1:0]); endfunction
  function is_inf;  input [W-1:0] x; is_inf = (&x[W-2:MW]) && !(|x[MW-1:0]); endfunction
  function [W-1:0] inf_of; input s; inf_of = {s, {EW{1'b1}}, {MW{1'b0}}}; endfunction

  // truncation toward zero: overflow clamps to the largest finite value
  function [W-1:0] pack_fp;
    input s;
    input integer e;
    input [MW-1:0] f;
    begin
      if (e <= 0)
        pack_fp = {s, {(W-1){1'b0}}};
      else if (e >= EMAX)
        pack_fp = {s, {(EW-1){1'b1}}, 1'b0, {MW{1'b1}}};
      else
        pack_fp = {s, e[EW-1:0], f};
    end
  endfunction

  function [A-1:0] shr_st;
    input [A-1:0] v;
    input integer n;
    reg [A-1:0] m;
    begin
      m = {A{1'b0}};
      if (n >= A) begin
        shr_st = {{(A-1){1'b0}}, |v};
      end else begin
        m = ~({A{1'b1}} << n);
        shr_st = (v >> n) | {{(A-1){1'b0}}, |(v & m)};
      end
    end
  endfunction

  // a +/- b*c with the exact product and one truncation at the end
  function [W-1:0] fma_core;
    input [W-1:0] a, b, c;
    input neg;
    reg [A-1:0] x, y, r;
    reg [P-1:0] pm;
    reg sp, sr;
    integer ea, ep, eg, pos, k;
    begin
      pm = {1'b1, b[MW-1:0]} * {1'b1, c[MW-1:0]};
      sp = b[W-1] ^ c[W-1] ^ neg;
      ea = is_zero(a) ? -1000 : a[W-2:MW];
      ep = (is_zero(b) || is_zero(c)) ? -1000 : b[W-2:MW] + c[W-2:MW] - BIAS;
      x = is_zero(a) ? {A{1'b0}} : {2'b00, 1'b1, a[MW-1:0], {MW{1'b0}}, 3'b000};
      y = (ep == -1000) ? {A{1'b0}} : {1'b0, pm, 3'b000};
      if (ea >= ep) begin
        y = shr_st(y, ea - ep);
        eg = ea;
      end else begin
        x = shr_st(x, ep - ea);
        eg = ep;
      end
      if (a[W-1] == sp) begin
        r = x + y;
        sr = sp;
      end else if (x >= y) begin
        r = x - y;
        sr = a[W-1];
      end else begin
        r = y - x;
        sr = sp;
      end
      pos = 0;
      for (k = 0; k < A; k = k + 1)
        if (r[k]) pos = k;
      if (r == {A{1'b0}}) begin
        fma_core = {W{1'b0}};
      end else begin
        r = r << (A - 1 - pos);
        fma_core = pack_fp(sr, eg + pos - (2 * MW + 3), r[A-2 -: MW]);
      end
    end
  endfunction

  function [W-1:0] fma_spec;
    input [W-1:0] a, b, c;
    input neg;
    reg pinf, pnan, ps;
    begin
      ps = b[W-1] ^ c[W-1] ^ neg;
      pinf = is_inf(b) || is_inf(c);
      pnan = is_nan(b) || is_nan(c) || (pinf && (is_zero(b) || is_zero(c)));
      if (handle_specials && (pnan || is_nan(a) || (pinf && is_inf(a) && a[W-1] != ps)))
        fma_spec = QNAN;
      else if (handle_specials && pinf)
        fma_spec = inf_of(ps);
      else if (handle_specials && is_inf(a))
        fma_spec = a;
      else
        fma_spec = fma_core(a, b, c, neg);
    end
  endfunction

  // radix-4 long division, two quotient bits per step, truncated
  function [W-1:0] div_core;
    input [W-1:0] a, b;
    reg [MW+3:0] r, d;
    reg [2*DN:0] q;
    reg s;
    integer k, e;
    begin
      s = a[W-1] ^ b[W-1];
      d = {3'b000, 1'b1, b[MW-1:0]};
      r = {3'b000, 1'b1, a[MW-1:0]};
      q = {(2*DN+1){1'b0}};
      if (r >= d) begin
        r = r - d;
        q[0] = 1'b1;
      end
      for (k = 0; k < DN; k = k + 1) begin
        r = {r[MW+1:0], 2'b00};
        if (r >= 3 * d) begin
          r = r - 3 * d;
          q = {q[2*DN-2:0], 2'b11};
        end else if (r >= {d[MW+2:0], 1'b0}) begin
          r = r - {d[MW+2:0], 1'b0};
          q = {q[2*DN-2:0], 2'b10};
        end else if (r >= d) begin
          r = r - d;
          q = {q[2*DN-2:0], 2'b01};
        end else begin
          q = {q[2*DN-2:0], 2'b00};
        end
      end
      e = a[W-2:MW] - b[W-2:MW] + BIAS;
      if (is_nan(a) || is_nan(b) || (is_inf(a) && is_inf(b)) || (is_zero(a) && is_zero(b)))
        div_core = QNAN;
      else if (is_inf(a) || is_zero(b))
        div_core = inf_of(s);
      else if (is_inf(b) || is_zero(a))
        div_core = {s, {(W-1){1'b0}}};
      else if (q[2*DN])
        div_core = pack_fp(s, e, q[2*DN-1 -: MW]);
      else
        div_core = pack_fp(s, e - 1, q[2*DN-2 -: MW]);
    end
  endfunction

  // restoring digit-by-digit root, one result bit per step
  function [W-1:0] sqrt_core;
    input [W-1:0] a;
    reg [2*MW+1:0] rad;
    reg [MW+3:0] rem, t;
    reg [MW:0] root;
    integer k, e;
    begin
      e = a[W-2:MW] - BIAS;
      rad = {1'b0, 1'b1, a[MW-1:0], {MW{1'b0}}};
      if (e[0]) begin
        rad = {rad[2*MW:0], 1'b0};
        e = e - 1;
      end
      rem = {(MW+4){1'b0}};
      root = {(MW+1){1'b0}};
      for (k = MW; k >= 0; k = k - 1) begin
        rem = {rem[MW+1:0], rad[2*k+1 -: 2]};
        t = {1'b0, root, 2'b01};
        if (rem >= t) begin
          rem = rem - t;
          root = {root[MW-1:0], 1'b1};
        end else begin
          root = {root[MW-1:0], 1'b0};
        end
      end
      if (is_zero(a))
        sqrt_core = {a[W-1], {(W-1){1'b0}}};
      else if (is_nan(a) || a[W-1])
        sqrt_core = QNAN;
      else if (is_inf(a))
        sqrt_core = a;
      else
        sqrt_core = pack_fp(1'b0, e / 2 + BIAS, root[MW-1:0]);
    end
  endfunction

  function [W-1:0] int_to_fp;
    input [IW-1:0] v;
    input sgn;
    reg [IW-1:0] mag, sh, lowm;
    reg [MW:0] fr;
    reg s;
    integer pos, k, e;
    begin
      s = sgn & v[IW-1];
      mag = s ? (~v + 1'b1) : v;
      pos = 0;
      for (k = 0; k < IW; k = k + 1)
        if (mag[k]) pos = k;
      sh = mag << (IW - 1 - pos);
      lowm = ~({IW{1'b1}} << (IW - 2 - MW));
      fr = {1'b0, sh[IW-2 -: MW]};
      e = BIAS + pos;
      if (sh[IW-2-MW] && ((|(sh & lowm)) || fr[0]))
        fr = fr + 1'b1;
      if (fr[MW])
        e = e + 1;
      int_to_fp = (mag == {IW{1'b0}}) ? {W{1'b0}} : {s, e[EW-1:0], fr[MW-1:0]};
    end
  endfunction

  function [IW-1:0] fp_to_int;
    input [W-1:0] f;
    input sgn;
    reg [IW+MW:0] w, ip, m;
    reg up;
    integer e, n;
    begin
      e = f[W-2:MW] - BIAS;
      w = {{IW{1'b0}}, 1'b1, f[MW-1:0]};
      ip = {(IW+MW+1){1'b0}};
      up = 1'b0;
      if (e >= MW) begin
        ip = w << (e - MW);
      end else if (e >= -1) begin
        n = MW - e;
        m = ~({(IW+MW+1){1'b1}} << (n - 1));
        ip = w >> n;
        up = w[n-1] && ((|(w & m)) || ip[0]);
      end
      ip = ip + up;
      if (is_nan(f) || is_zero(f) || e < -1)
        fp_to_int = {IW{1'b0}};
      else if (!sgn && f[W-1])
        fp_to_int = {IW{1'b0}};
      else if (!sgn)
        fp_to_int = (e >= IW || ip[IW+MW:IW] != 0) ? {IW{1'b1}} : ip[IW-1:0];
      else if (f[W-1])
        fp_to_int = (e >= IW || ip > {1'b1, {(IW-1){1'b0}}}) ? {1'b1, {(IW-1){1'b0}}} : ~ip[IW-1:0] + 1'b1;
      else
        fp_to_int = (e >= IW || ip >= {1'b1, {(IW-1){1'b0}}}) ? {1'b0, {(IW-1){1'b1}}} : ip[IW-1:0];
    end
  endfunction

  // signed ordering key; both zeros map to the same key
  function signed [W:0] ord_key;
    input [W-1:0] x;
    begin
      if (is_zero(x))
        ord_key = {(W+1){1'b0}};
      else if (x[W-1])
        ord_key = -$signed({2'b00, x[W-2:0]});
      else
        ord_key = $signed({2'b00, x[W-2:0]});
    end
  endfunction

  reg [W-1:0] mac2_data, conv_data, cmp_data;
  reg         cmp_bit;
  reg         unord;
  reg signed [W:0] ka, kb;

  always @* begin
    case (opcode)
      `OP_MSU2: mac2_data = fma_spec(operand_a, operand_b, operand_c, 1'b1);
      `OP_ADD2: mac2_data = fma_spec(operand_a, operand_b, ONE, 1'b0);
      `OP_SUB2: mac2_data = fma_spec(operand_a, operand_b, ONE, 1'b1);
      `OP_MUL2: mac2_data = fma_spec({W{1'b0}}, operand_a, operand_b, 1'b0);
      default:  mac2_data = fma_spec(operand_a, operand_b, operand_c, 1'b0);
    endcase
    case (opcode)
      `OP_CIFU: conv_data = int_to_fp(operand_a[IW-1:0], 1'b0);
      `OP_CFI:  conv_data = fp_to_int(operand_a, 1'b1);
      `OP_CFIU: conv_data = fp_to_int(operand_a, 1'b0);
      default:  conv_data = int_to_fp(operand_a[IW-1:0], 1'b1);
    endcase
    ka = ord_key(operand_a);
    kb = ord_key(operand_b);
    unord = is_nan(operand_a) || is_nan(operand_b);
    case (opcode)
      `OP_EQ:  cmp_bit = !unord && ka == kb;
      `OP_NE:  cmp_bit = unord || ka != kb;
      `OP_GT:  cmp_bit = !unord && ka > kb;
      `OP_GE:  cmp_bit = !unord && ka >= kb;
      `OP_LT:  cmp_bit = !unord && ka < kb;
      default: cmp_bit = !unord && ka <= kb;
    endcase
    if (opcode == `OP_ABS)
      cmp_data = is_zero(operand_a) ? {W{1'b0}} : {1'b0, operand_a[W-2:0]};
    else if (opcode == `OP_NEG)
      cmp_data = is_zero(operand_a) ? {~operand_a[W-1], {(W-1){1'b0}}} : {~operand_a[W-1], operand_a[W-2:0]};
    else
      cmp_data = {{(W-1){1'b0}}, cmp_bit};
  end

  wire add_go  = trigger && (opcode == `OP_ADD || opcode == `OP_SUB);
  wire mac_go  = trigger && (opcode == `OP_MAC || opcode == `OP_MSU);
  wire mac2_go = trigger && opcode >= `OP_MAC2 && opcode <= `OP_MUL2;
  wire conv_go = trigger && opcode >= `OP_CIF && opcode <= `OP_CFIU;
  wire cmp_go  = trigger && opcode[4] && opcode <= `OP_NEG;

  result_pipe #(.LAT(`LAT_ADD), .W(W)) add_pipe (.mclk(mclk), .rstn(rstn), .in_valid(add_go),
    .in_data(fma_spec(operand_a, operand_b, ONE, opcode == `OP_SUB)), .out_valid(add_valid), .out_data(add_result));
  result_pipe #(.LAT(`LAT_MUL), .W(W)) mul_pipe (.mclk(mclk), .rstn(rstn), .in_valid(trigger && opcode == `OP_MUL),
    .in_data(fma_spec({W{1'b0}}, operand_a, operand_b, 1'b0)), .out_valid(mul_valid), .out_data(mul_result));
  result_pipe #(.LAT(LAT_DIV), .W(W)) div_pipe (.mclk(mclk), .rstn(rstn), .in_valid(trigger && opcode == `OP_DIV),
    .in_data(div_core(operand_a, operand_b)), .out_valid(div_valid), .out_data(div_result));
  // first variant skips special-value handling to keep the path short
  result_pipe #(.LAT(`LAT_MAC), .W(W)) mac_pipe (.mclk(mclk), .rstn(rstn), .in_valid(mac_go),
    .in_data(fma_core(operand_a, operand_b, operand_c, opcode == `OP_MSU)), .out_valid(mac_valid),
    .out_data(mac_result));
  result_pipe #(.LAT(`LAT_MAC), .W(W)) mac2_pipe (.mclk(mclk), .rstn(rstn), .in_valid(mac2_go),
    .in_data(mac2_data), .out_valid(mac2_valid), .out_data(mac2_result));
  result_pipe #(.LAT(LAT_SQRT), .W(W)) sqrt_pipe (.mclk(mclk), .rstn(rstn), .in_valid(trigger && opcode == `OP_SQRT),
    .in_data(sqrt_core(operand_a)), .out_valid(sqrt_valid), .out_data(sqrt_result));
  result_pipe #(.LAT(`LAT_CONV), .W(W)) conv_pipe (.mclk(mclk), .rstn(rstn), .in_valid(conv_go),
    .in_data(conv_data), .out_valid(conv_valid), .out_data(conv_result));
  result_pipe #(.LAT(`LAT_CMP), .W(W)) cmp_pipe (.mclk(mclk), .rstn(rstn), .in_valid(cmp_go),
    .in_data(cmp_data), .out_valid(cmp_valid), .out_data(cmp_result));
endmodule

/* test/float_unit_checker.sv */
// timing checker for the floating-point unit set: issue-to-valid latencies.
// assumes one clock, async active-low reset, one operation taken per trigger edge.
`timescale 1ns/1ps
`include "float_map.vh"
module float_unit_checker #(
  parameter mantissa_width = 23,
  parameter exponent_width = 8
) (
  input wire                                   mclk,
  input wire                                   rstn,
  input wire                                   trigger,
  input wire [4:0]                             opcode,
  input wire                                   add_valid,
  input wire                                   mul_valid,
  input wire                                   div_valid,
  input wire                                   mac_valid,
  input wire                                   mac2_valid,
  input wire                                   sqrt_valid,
  input wire                                   conv_valid,
  input wire                                   cmp_valid,
  input wire [exponent_width+mantissa_width:0] cmp_result
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire t_add  = trigger & (opcode == `OP_ADD | opcode == `OP_SUB);
  wire t_mul  = trigger & (opcode == `OP_MUL);
  wire t_div  = trigger & (opcode == `OP_DIV);
  wire t_mac  = trigger & (opcode == `OP_MAC | opcode == `OP_MSU);
  wire t_mac2 = trigger & (opcode >= `OP_MAC2) & (opcode <= `OP_MUL2);
  wire t_sqrt = trigger & (opcode == `OP_SQRT);
  wire t_conv = trigger & (opcode[4:2] == 3'b011);
  wire t_cmp  = trigger & (opcode[4:3] == 2'b10);
  // only the six relations give a one-bit answer; abs and negate return a float
  wire t_bool = t_cmp & (opcode <= `OP_LE);
  property p_add_lat; t_add |-> ##5 add_valid; endproperty
  a_add_lat: assert property (p_add_lat) else $error("add valid not 5 cycles after issue");
  property p_add_src; add_valid |-> $past(t_add, 5); endproperty
  a_add_src: assert property (p_add_src) else $error("add valid without matching issue");
  property p_mul_lat; t_mul |-> ##5 mul_valid; endproperty
  a_mul_lat: assert property (p_mul_lat) else $error("mul valid not 5 cycles after issue");
  property p_div_lat; t_div |-> ##15 div_valid; endproperty
  a_div_lat: assert property (p_div_lat) else $error("div valid not 15 cycles after issue");
  property p_mac_lat; t_mac |-> ##6 mac_valid; endproperty
  a_mac_lat: assert property (p_mac_lat) else $error("mac valid not 6 cycles after issue");
  property p_mac2_lat; t_mac2 |-> ##6 mac2_valid; endproperty
  a_mac2_lat: assert property (p_mac2_lat) else $error("mac2 valid not 6 cycles after issue");
  property p_sqrt_lat; t_sqrt |-> ##26 sqrt_valid; endproperty
  a_sqrt_lat: assert property (p_sqrt_lat) else $error("sqrt valid not 26 cycles after issue");
  property p_conv_lat; t_conv |-> ##4 conv_valid; endproperty
  a_conv_lat: assert property (p_conv_lat) else $error("conv valid not 4 cycles after issue");
  property p_cmp_lat; t_cmp |=> cmp_valid; endproperty
  a_cmp_lat: assert property (p_cmp_lat) else $error("cmp valid not 1 cycle after issue");
  property p_cmp_bool; cmp_valid && $past(t_bool) |-> cmp_result[exponent_width+mantissa_width:1] == '0; endproperty
  a_cmp_bool: assert property (p_cmp_bool) else $error("compare result has upper bits set");
  c_b2b_add: cover property (t_add ##1 t_add ##1 t_add);
  c_div_done: cover property (div_valid);
  c_cmp_true: cover property (cmp_valid && cmp_result[0]);
endmodule

bind float_unit_set float_unit_checker #(.mantissa_width(mantissa_width), .exponent_width(exponent_width))
  i_float_unit_checker (.mclk(mclk), .rstn(rstn), .trigger(trigger), .opcode(opcode),
  .add_valid(add_valid), .mul_valid(mul_valid), .div_valid(div_valid), .mac_valid(mac_valid),
  .mac2_valid(mac2_valid), .sqrt_valid(sqrt_valid), .conv_valid(conv_valid), .cmp_valid(cmp_valid),
  .cmp_result(cmp_result));

/* test/op_issuer.sv */
// issuing side model: queued operations leave one per falling edge, back to back.
// assumes the bench fills the queue through push between edges.
`timescale 1ns/1ps
module op_issuer (
  input  wire        mclk,
  output reg         trigger,
  output reg  [4:0]  opcode,
  output reg  [31:0] operand_a,
  output reg  [31:0] operand_b,
  output reg  [31:0] operand_c
);
  logic [100:0] q[$];
  initial {trigger, opcode, operand_a, operand_b, operand_c} = '0;
  task automatic push(input logic [4:0] op, input logic [31:0] a, input logic [31:0] b, input logic [31:0] c);
    q.push_back({op, a, b, c});
  endtask
  always @(negedge mclk) begin
    if (q.size() > 0) begin
      {opcode, operand_a, operand_b, operand_c} <= q.pop_front();
      trigger <= 1'b1;
    end else begin
      // idle lanes toggle so a design sampling without trigger shows up
      trigger <= 1'b0;
      {opcode, operand_a, operand_b, operand_c} <= ~{opcode, operand_a, operand_b, operand_c};
    end
  end
endmodule

/* test/tb_top.sv */
// self-checking bench for the floating-point unit set: table of operations, then back-to-back, bad code, reset.
// assumes the issuer model drives trigger and operands; latency is judged by the bound checker.
`timescale 1ns/1ps
`include "float_map.vh"
module tb_top;
  typedef struct {int u; logic [4:0] op; logic [31:0] a, b, c, e;} row_t;
  logic        mclk;
  logic        rstn;
  wire         trigger;
  wire  [4:0]  opcode;
  wire  [31:0] operand_a, operand_b, operand_c;
  wire  [31:0] res [0:7];
  wire  [7:0]  vld;
  int          failures, checks_done, cycles, i;
  logic [31:0] got;
  logic [7:0]  seen;
  row_t        rows [0:26];

  op_issuer i_op_issuer (.mclk(mclk), .trigger(trigger), .opcode(opcode), .operand_a(operand_a),
    .operand_b(operand_b), .operand_c(operand_c));
  float_unit_set #(.mantissa_width(23), .exponent_width(8), .int_width(32), .handle_specials(1)) i_float_unit_set (
    .mclk(mclk), .rstn(rstn), .trigger(trigger), .opcode(opcode), .operand_a(operand_a), .operand_b(operand_b),
    .operand_c(operand_c), .add_result(res[0]), .add_valid(vld[0]), .mul_result(res[1]), .mul_valid(vld[1]),
    .div_result(res[2]), .div_valid(vld[2]), .mac_result(res[3]), .mac_valid(vld[3]), .mac2_result(res[4]),
    .mac2_valid(vld[4]), .sqrt_result(res[5]), .sqrt_valid(vld[5]), .conv_result(res[6]), .conv_valid(vld[6]),
    .cmp_result(res[7]), .cmp_valid(vld[7]));

  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  task automatic wrap_up;
    $display("checks_done %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check32(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask
  // quotient may sit a few units off, so sign and exponent must match and the value may differ by up to 4 units
  task automatic check_near(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g[31:23] !== e[31:23] || (g > e ? g - e : e - g) > 32'h4) begin
      failures++;
      $display("[ERR] %0t quotient %h not near %h", $time, g, e);
    end
  endtask
  task automatic wait_unit(input int u, output logic [31:0] r);
    r = 32'hXXXXXXXX;
    repeat (40) begin
      @(posedge mclk);
      #1;
      if (vld[u] === 1'b1) begin
        r = res[u];
        return;
      end
    end
  endtask
  task automatic watch(input int n);
    seen = 8'h00;
    repeat (n) begin
      @(posedge mclk);
      #1;
      seen = seen | vld;
    end
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up;
    end
  end

  initial begin
    rstn = 1'b0;
    rows[0]  = '{0, `OP_ADD,  32'h3F800000, 32'h40000000, 32'h0, 32'h40400000};
    rows[1]  = '{0, `OP_SUB,  32'h3F800000, 32'h3F800000, 32'h0, 32'h00000000};
    rows[2]  = '{0, `OP_ADD,  32'h3F800000, 32'h33800001, 32'h0, 32'h3F800000};
    rows[3]  = '{0, `OP_ADD,  32'h00000001, 32'h00000000, 32'h0, 32'h00000000};
    rows[4]  = '{1, `OP_MUL,  32'h3FC00000, 32'h40000000, 32'h0, 32'h40400000};
    rows[5]  = '{1, `OP_MUL,  32'h00800000, 32'h3F000000, 32'h0, 32'h00000000};
    rows[6]  = '{2, `OP_DIV,  32'h40C00000, 32'h40000000, 32'h0, 32'h40400000};
    rows[7]  = '{2, `OP_DIV,  32'h3F800000, 32'h40400000, 32'h0, 32'h3EAAAAAB};
    rows[8]  = '{3, `OP_MAC,  32'h3F800000, 32'h40000000, 32'h40400000, 32'h40E00000};
    rows[9]  = '{3, `OP_MSU,  32'h3F800000, 32'h40000000, 32'h40400000, 32'hC0A00000};
    rows[10] = '{4, `OP_MAC2, 32'h40000000, 32'h40400000, 32'h40800000, 32'h41600000};
    rows[11] = '{4, `OP_MSU2, 32'h40000000, 32'h40400000, 32'h40800000, 32'hC1200000};
    rows[12] = '{4, `OP_ADD2, 32'h3FC00000, 32'h40100000, 32'h0, 32'h40700000};
    rows[13] = '{4, `OP_SUB2, 32'h3F800000, 32'h40000000, 32'h0, 32'hBF800000};
    rows[14] = '{4, `OP_MUL2, 32'h40400000, 32'h40000000, 32'h0, 32'h40C00000};
    rows[15] = '{5, `OP_SQRT, 32'h40800000, 32'h0, 32'h0, 32'h40000000};
    rows[16] = '{6, `OP_CIF,  32'h01000003, 32'h0, 32'h0, 32'h4B800002};
    rows[17] = '{6, `OP_CIFU, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h4F800000};
    rows[18] = '{6, `OP_CFI,  32'h40200000, 32'h0, 32'h0, 32'h00000002};
    rows[19] = '{6, `OP_CFIU, 32'h40600000, 32'h0, 32'h0, 32'h00000004};
    rows[20] = '{7, `OP_EQ,   32'h00000000, 32'h80000000, 32'h0, 32'h00000001};
    rows[21] = '{7, `OP_NE,   32'h3F800000, 32'h40000000, 32'h0, 32'h00000001};
    rows[22] = '{7, `OP_GT,   32'h40000000, 32'h3F800000, 32'h0, 32'h00000001};
    rows[23] = '{7, `OP_GE,   32'h3F800000, 32'h40000000, 32'h0, 32'h00000000};
    rows[24] = '{7, `OP_LT,   32'h3F800000, 32'h40000000, 32'h0, 32'h00000001};
    rows[25] = '{7, `OP_LE,   32'h40000000, 32'h40000000, 32'h0, 32'h00000001};
    rows[26] = '{7, `OP_ABS,  32'hC0400000, 32'h0, 32'h0, 32'h40400000};
    repeat (4) @(negedge mclk);
    check32({24'h0, vld}, 32'h0); // RESET
    rstn = 1'b1;
    for (i = 0; i < 27; i++) begin
      i_op_issuer.push(rows[i].op, rows[i].a, rows[i].b, rows[i].c);
      wait_unit(rows[i].u, got);
      if (rows[i].u == 2) check_near(got, rows[i].e);
      else check32(got, rows[i].e);
    end
    for (i = 0; i < 4; i++) i_op_issuer.push(`OP_ADD, 32'h3F800000 + (i << 23), 32'h3F800000 + (i << 23), 32'h0);
    i_op_issuer.push(`OP_NEG, 32'h3F800000, 32'h0, 32'h0);
    wait_unit(0, got);
    for (i = 0; i < 4; i++) begin
      check32(res[0], 32'h40000000 + (i << 23));
      check32({31'h0, vld[0]}, 32'h1);
      // the negate is taken four edges after the first add, so its answer stands beside that sum
      if (i == 0) check32(res[7], 32'hBF800000);
      if (i == 0) check32({31'h0, vld[7]}, 32'h1);
      @(posedge mclk);
      #1;
    end
    i_op_issuer.push(5'h18, 32'h3F800000, 32'h3F800000, 32'h3F800000);
    watch(30);
    check32({24'h0, seen}, 32'h0);
    i_op_issuer.push(`OP_SQRT, 32'h40800000, 32'h0, 32'h0);
    repeat (6) @(negedge mclk);
    rstn = 1'b0;
    @(negedge mclk);
    check32({24'h0, vld}, 32'h0); // RESET
    check32(res[0] | res[5], 32'h0); // RESET
    rstn = 1'b1;
    watch(30);
    check32({24'h0, seen}, 32'h0); // RESET
    wrap_up;
  end
endmodule
